// ### design/rrc_params.svh
`ifndef RRC_PARAMS_SVH
`define RRC_PARAMS_SVH

// Register addresses on the serial control port.
`define RRC_ADDR_SPEED_MODE      8'h1c
`define RRC_ADDR_SPEED_OVR       8'h1d
`define RRC_ADDR_INPUT_OVR_ROUTE 8'h1e
`define RRC_ADDR_RSVD_1F         8'h1f
`define RRC_ADDR_DETECT_CHANNEL  8'h20
`define RRC_ADDR_RSVD_21         8'h21
`define RRC_ADDR_LAST            8'h21
`define RRC_NUM_REGS             6

// Reset values.
`define RRC_RST_SPEED_MODE       8'h64
`define RRC_RST_SPEED_OVR        8'h80
`define RRC_RST_INPUT_OVR_ROUTE  8'h0b
`define RRC_RST_RSVD_1F          8'h55
`define RRC_RST_DETECT_CHANNEL   8'h18
`define RRC_RST_RSVD_21          8'h05

// Register array indices.
`define RRC_IDX_SPEED_MODE       3'h0
`define RRC_IDX_SPEED_OVR        3'h1
`define RRC_IDX_INPUT_OVR_ROUTE  3'h2
`define RRC_IDX_DETECT_CHANNEL   3'h4

// Field positions.
`define RRC_SPEED_MODE_MSB       1
`define RRC_SPEED_MODE_LSB       0
`define RRC_SPEED_OVR_BIT        0
`define RRC_INPUT_OVR_BIT        7
`define RRC_FIRST_ROUTE_MSB      6
`define RRC_FIRST_ROUTE_LSB      5
`define RRC_SECOND_ROUTE_MSB     4
`define RRC_SECOND_ROUTE_LSB     3
`define RRC_FORCE_ON_BIT         7
`define RRC_FORCE_OFF_BIT        6
`define RRC_LEVEL_MSB            5
`define RRC_LEVEL_LSB            3
`define RRC_CHANNEL_MSB          2
`define RRC_CHANNEL_LSB          1

// Routing codes used while manual routing is not honoured.
`define RRC_PIN_FIRST_ROUTE      2'h0
`define RRC_PIN_SECOND_ROUTE     2'h1

// Signal-detect thresholds in mV, assert then de-assert.
`define RRC_LVL_MIN              3'h3
`define RRC_LVL_3_ASSERT_MV      9'h070
`define RRC_LVL_3_DEASSERT_MV    9'h04e
`define RRC_LVL_4_ASSERT_MV      9'h08e
`define RRC_LVL_4_DEASSERT_MV    9'h070
`define RRC_LVL_5_ASSERT_MV      9'h0b4
`define RRC_LVL_5_DEASSERT_MV    9'h08e
`define RRC_LVL_6_ASSERT_MV      9'h0da
`define RRC_LVL_6_DEASSERT_MV    9'h0b4
`define RRC_LVL_7_ASSERT_MV      9'h100
`define RRC_LVL_7_DEASSERT_MV    9'h0da
`define RRC_ZERO_MV              9'h000

`endif

// ### design/rrc_pkg.sv
package rrc_pkg;

  typedef enum logic [1:0] {
    RRC_SPEED_AUTO   = 2'h0,
    RRC_SPEED_SD270  = 2'h1,
    RRC_SPEED_HD3G   = 2'h2,
    RRC_SPEED_M125   = 2'h3
  } rrc_speed_t;

  typedef enum logic [1:0] {
    RRC_SRC_RECLOCKED = 2'h0,
    RRC_SRC_BYPASS    = 2'h1,
    RRC_SRC_CLOCK     = 2'h2,
    RRC_SRC_MUTE      = 2'h3
  } rrc_src_t;

endpackage : rrc_pkg

// ### design/rrc_route_config.sv
// Overview of operation
// - Speed code picks auto, 270, HD/3G, 125.
// - Speed register used only when override set.
// - Input override picks register channel over pins.
// - Channel code routes input 0..3 onward.
// - Manual routing honoured only with pin-mode override.
// - First output: reclocked/bypass, bypass, mute.
// - Second output: clock/mute, reclocked/bypass, mute, bypass.
// - Level code 011..111 sets thresholds; others reserved.
// - Reset gives second route 01, level 011.
`timescale 1ns/1ns
`default_nettype none
`include "rrc_params.svh"

module rrc_route_config
  import rrc_pkg::*;
(
  input  wire logic       CLK_SYS_I,
  input  wire logic       SYS_RST_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic       REG_WR_EN_I,
  input  wire logic [7:0] REG_WR_DATA_I,
  input  wire logic       REG_RD_EN_I,
  output logic      [7:0] REG_RD_DATA_O,
  input  wire logic       PIN_MODE_OVERRIDE_I,
  input  wire logic [1:0] SPEED_PINS_I,
  input  wire logic [1:0] SELECT_PINS_I,
  input  wire logic [3:0] SERIAL_IN_I,
  input  wire logic       LOCKED_I,
  output var rrc_speed_t  SPEED_MODE_O,
  output logic      [1:0] INPUT_CHANNEL_O,
  output logic            RECLOCK_IN_O,
  output var rrc_src_t    FIRST_OUT_SRC_O,
  output var rrc_src_t    SECOND_OUT_SRC_O,
  output logic      [8:0] DETECT_ASSERT_MV_O,
  output logic      [8:0] DETECT_DEASSERT_MV_O,
  output logic            DETECT_LEVEL_VALID_O,
  output logic            DETECT_FORCE_ON_O,
  output logic            DETECT_FORCE_OFF_O
);

  // First output source for a routing code and the lock state.
  function automatic rrc_src_t first_src(input logic [1:0] code, input logic locked);
    rrc_src_t src;
    unique case (code)
      2'h1:    src = RRC_SRC_BYPASS;
      2'h2:    src = RRC_SRC_MUTE;
      default: src = locked ? RRC_SRC_RECLOCKED : RRC_SRC_BYPASS;
    endcase
    return src;
  endfunction : first_src

  // Second output source for a routing code and the lock state.
  function automatic rrc_src_t second_src(input logic [1:0] code, input logic locked);
    rrc_src_t src;
    unique case (code)
      2'h0:    src = locked ? RRC_SRC_CLOCK : RRC_SRC_MUTE;
      2'h1:    src = locked ? RRC_SRC_RECLOCKED : RRC_SRC_BYPASS;
      2'h2:    src = RRC_SRC_MUTE;
      default: src = RRC_SRC_BYPASS;
    endcase
    return src;
  endfunction : second_src

  // Pins from outside the clock domain, synchronised as one vector.
  // Only the second stage is read by logic, so a metastable first stage never spreads.
  logic [7:0] sync_a_reg;
  logic [7:0] sync_a_next;
  logic [7:0] sync_b_reg;
  logic [7:0] sync_b_next;

  always_comb begin
    sync_a_next = {SERIAL_IN_I, SELECT_PINS_I, SPEED_PINS_I};
    sync_b_next = sync_a_reg;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      sync_a_reg <= 8'h00;
      sync_b_reg <= 8'h00;
    end else begin
      sync_a_reg <= sync_a_next;
      sync_b_reg <= sync_b_next;
    end
  end

  logic [1:0] speed_pins_s;
  logic [1:0] select_pins_s;
  logic [3:0] serial_in_s;

  assign speed_pins_s  = sync_b_reg[1:0];
  assign select_pins_s = sync_b_reg[3:2];
  assign serial_in_s   = sync_b_reg[7:4];

  // Register file.
  logic [7:0] regs_reg  [`RRC_NUM_REGS];
  logic [7:0] regs_next [`RRC_NUM_REGS];
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic       in_range;
  logic [2:0] reg_idx;
  logic [7:0] rst_vals [`RRC_NUM_REGS];

  assign rst_vals[0] = `RRC_RST_SPEED_MODE;
  assign rst_vals[1] = `RRC_RST_SPEED_OVR;
  assign rst_vals[2] = `RRC_RST_INPUT_OVR_ROUTE;
  assign rst_vals[3] = `RRC_RST_RSVD_1F;
  assign rst_vals[4] = `RRC_RST_DETECT_CHANNEL;
  assign rst_vals[5] = `RRC_RST_RSVD_21;

  // Addresses outside this slice are ignored on write and read back as zero.
  assign in_range = (REG_ADDR_I >= `RRC_ADDR_SPEED_MODE) && (REG_ADDR_I <= `RRC_ADDR_LAST);
  assign reg_idx  = 3'(REG_ADDR_I - `RRC_ADDR_SPEED_MODE);

  // Reserved bits are stored as written; the block does not guard them.
  always_comb begin
    for (int i = 0; i < `RRC_NUM_REGS; i++) begin
      regs_next[i] = regs_reg[i];
    end
    if (REG_WR_EN_I && in_range) begin
      regs_next[reg_idx] = REG_WR_DATA_I;
    end
    rd_data_next = rd_data_reg;
    if (REG_RD_EN_I) begin
      rd_data_next = in_range ? regs_reg[reg_idx] : 8'h00;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `RRC_NUM_REGS; g++) begin : g_regs
      always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
          regs_reg[g] <= rst_vals[g];
        end else begin
          regs_reg[g] <= regs_next[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // Field views.
  logic [7:0] speed_mode_r;
  logic [7:0] speed_ovr_r;
  logic [7:0] route_r;
  logic [7:0] detect_r;
  logic [2:0] level_code;

  assign speed_mode_r = regs_reg[`RRC_IDX_SPEED_MODE];
  assign speed_ovr_r  = regs_reg[`RRC_IDX_SPEED_OVR];
  assign route_r      = regs_reg[`RRC_IDX_INPUT_OVR_ROUTE];
  assign detect_r     = regs_reg[`RRC_IDX_DETECT_CHANNEL];
  assign level_code   = detect_r[`RRC_LEVEL_MSB:`RRC_LEVEL_LSB];

  // Effective controls, registered so every data output comes from a flip-flop.
  rrc_speed_t speed_reg;
  rrc_speed_t speed_next;
  logic [1:0] channel_reg;
  logic [1:0] channel_next;
  logic       reclock_in_reg;
  logic       reclock_in_next;
  rrc_src_t   first_reg;
  rrc_src_t   first_next;
  rrc_src_t   second_reg;
  rrc_src_t   second_next;
  logic [8:0] assert_mv_reg;
  logic [8:0] assert_mv_next;
  logic [8:0] deassert_mv_reg;
  logic [8:0] deassert_mv_next;
  logic       level_ok_reg;
  logic       level_ok_next;
  logic [1:0] first_code;
  logic [1:0] second_code;

  always_comb begin
    if (speed_ovr_r[`RRC_SPEED_OVR_BIT]) begin
      speed_next = rrc_speed_t'(speed_mode_r[`RRC_SPEED_MODE_MSB:`RRC_SPEED_MODE_LSB]);
    end else begin
      speed_next = rrc_speed_t'(speed_pins_s);
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      speed_reg <= RRC_SPEED_AUTO;
    end else begin
      speed_reg <= speed_next;
    end
  end

  // The selected input lags a channel change by one cycle, traded for a shorter mux path.
  always_comb begin
    if (route_r[`RRC_INPUT_OVR_BIT]) begin
      channel_next = detect_r[`RRC_CHANNEL_MSB:`RRC_CHANNEL_LSB];
    end else begin
      channel_next = select_pins_s;
    end
    reclock_in_next = serial_in_s[channel_reg];
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      channel_reg    <= 2'h0;
      reclock_in_reg <= 1'b0;
    end else begin
      channel_reg    <= channel_next;
      reclock_in_reg <= reclock_in_next;
    end
  end

  always_comb begin
    // Without the pin-mode override the outputs take their pin-mode routing.
    if (PIN_MODE_OVERRIDE_I) begin
      first_code  = route_r[`RRC_FIRST_ROUTE_MSB:`RRC_FIRST_ROUTE_LSB];
      second_code = route_r[`RRC_SECOND_ROUTE_MSB:`RRC_SECOND_ROUTE_LSB];
    end else begin
      first_code  = `RRC_PIN_FIRST_ROUTE;
      second_code = `RRC_PIN_SECOND_ROUTE;
    end
    first_next  = first_src(first_code, LOCKED_I);
    second_next = second_src(second_code, LOCKED_I);
  end

  // Both sources start at bypass, the safe pre-lock choice, until the first live recompute.
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      first_reg  <= RRC_SRC_BYPASS;
      second_reg <= RRC_SRC_BYPASS;
    end else begin
      first_reg  <= first_next;
      second_reg <= second_next;
    end
  end

  always_comb begin
    level_ok_next = 1'b1;
    unique case (level_code)
      3'h3: begin
        assert_mv_next   = `RRC_LVL_3_ASSERT_MV;
        deassert_mv_next = `RRC_LVL_3_DEASSERT_MV;
      end
      3'h4: begin
        assert_mv_next   = `RRC_LVL_4_ASSERT_MV;
        deassert_mv_next = `RRC_LVL_4_DEASSERT_MV;
      end
      3'h5: begin
        assert_mv_next   = `RRC_LVL_5_ASSERT_MV;
        deassert_mv_next = `RRC_LVL_5_DEASSERT_MV;
      end
      3'h6: begin
        assert_mv_next   = `RRC_LVL_6_ASSERT_MV;
        deassert_mv_next = `RRC_LVL_6_DEASSERT_MV;
      end
      3'h7: begin
        assert_mv_next   = `RRC_LVL_7_ASSERT_MV;
        deassert_mv_next = `RRC_LVL_7_DEASSERT_MV;
      end
      default: begin
        // Reserved codes give no threshold so the comparator can be held off.
        assert_mv_next   = `RRC_ZERO_MV;
        deassert_mv_next = `RRC_ZERO_MV;
        level_ok_next    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      assert_mv_reg   <= `RRC_LVL_3_ASSERT_MV;
      deassert_mv_reg <= `RRC_LVL_3_DEASSERT_MV;
      level_ok_reg    <= 1'b1;
    end else begin
      assert_mv_reg   <= assert_mv_next;
      deassert_mv_reg <= deassert_mv_next;
      level_ok_reg    <= level_ok_next;
    end
  end

  assign REG_RD_DATA_O        = rd_data_reg;
  assign SPEED_MODE_O         = speed_reg;
  assign INPUT_CHANNEL_O      = channel_reg;
  assign RECLOCK_IN_O         = reclock_in_reg;
  assign FIRST_OUT_SRC_O      = first_reg;
  assign SECOND_OUT_SRC_O     = second_reg;
  assign DETECT_ASSERT_MV_O   = assert_mv_reg;
  assign DETECT_DEASSERT_MV_O = deassert_mv_reg;
  assign DETECT_LEVEL_VALID_O = level_ok_reg;
  assign DETECT_FORCE_ON_O    = detect_r[`RRC_FORCE_ON_BIT];
  assign DETECT_FORCE_OFF_O   = detect_r[`RRC_FORCE_OFF_BIT];

endmodule : rrc_route_config
`default_nettype wire

// ### testbench/rrc_vfy_pkg.sv
package rrc_vfy_pkg;
  import rrc_pkg::*;

  function automatic rrc_src_t first_src(input logic [1:0] c, input logic lk);
    case (c)
      2'h1: return RRC_SRC_BYPASS;
      2'h2: return RRC_SRC_MUTE;
      default: return lk ? RRC_SRC_RECLOCKED : RRC_SRC_BYPASS;
    endcase
  endfunction : first_src

  function automatic rrc_src_t second_src(input logic [1:0] c, input logic lk);
    case (c)
      2'h0: return lk ? RRC_SRC_CLOCK : RRC_SRC_MUTE;
      2'h1: return lk ? RRC_SRC_RECLOCKED : RRC_SRC_BYPASS;
      2'h2: return RRC_SRC_MUTE;
      default: return RRC_SRC_BYPASS;
    endcase
  endfunction : second_src

  function automatic logic [17:0] thr(input logic [2:0] c);
    case (c)
      3'h3: return {9'h070, 9'h04e};
      3'h4: return {9'h08e, 9'h070};
      3'h5: return {9'h0b4, 9'h08e};
      3'h6: return {9'h0da, 9'h0b4};
      3'h7: return {9'h100, 9'h0da};
      default: return 18'h00000;
    endcase
  endfunction : thr
endpackage : rrc_vfy_pkg

// ### testbench/rrc_host.sv
`timescale 1ns/1ns
`default_nettype none
module rrc_host (
  input  wire logic       clk_i,
  output logic      [7:0] addr_o,
  output logic            wr_en_o,
  output logic      [7:0] wr_data_o,
  output logic            rd_en_o,
  input  wire logic [7:0] rd_data_i
);
  // Callers keep reserved fields at their defaults.
  initial begin
    addr_o = 8'h00;
    wr_en_o = 1'b0;
    wr_data_o = 8'h00;
    rd_en_o = 1'b0;
  end

  // Idle address and data are inverted so a stale value is never mistaken for a request.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wr_data_o <= d;
    wr_en_o <= 1'b1;
    @(posedge clk_i);
    addr_o <= ~a;
    wr_data_o <= ~d;
    wr_en_o <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_en_o <= 1'b1;
    @(posedge clk_i);
    addr_o <= ~a;
    rd_en_o <= 1'b0;
    #1 d = rd_data_i;
  endtask : rd
endmodule : rrc_host
`default_nettype wire

// ### testbench/rrc_route_config_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module rrc_route_config_asserts
  import rrc_pkg::*, rrc_vfy_pkg::*;
(
  input wire logic       CLK_SYS_I,
  input wire logic       SYS_RST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic       REG_WR_EN_I,
  input wire logic [7:0] REG_WR_DATA_I,
  input wire logic       REG_RD_EN_I,
  input wire logic [7:0] REG_RD_DATA_O,
  input wire logic       PIN_MODE_OVERRIDE_I,
  input wire logic [1:0] SPEED_PINS_I,
  input wire logic       LOCKED_I,
  input var rrc_speed_t  SPEED_MODE_O,
  input wire logic [1:0] INPUT_CHANNEL_O,
  input var rrc_src_t    FIRST_OUT_SRC_O,
  input var rrc_src_t    SECOND_OUT_SRC_O,
  input wire logic [8:0] DETECT_ASSERT_MV_O,
  input wire logic [8:0] DETECT_DEASSERT_MV_O,
  input wire logic       DETECT_LEVEL_VALID_O
);
  // Shadow copies of the four control registers, kept from the observed writes.
  logic [7:0] sm_reg, so_reg, io_reg, dc_reg, sm_next, so_next, io_next, dc_next;
  always_comb begin
    {sm_next, so_next, io_next, dc_next} = {sm_reg, so_reg, io_reg, dc_reg};
    if (REG_WR_EN_I && REG_ADDR_I == 8'h1c) sm_next = REG_WR_DATA_I;
    if (REG_WR_EN_I && REG_ADDR_I == 8'h1d) so_next = REG_WR_DATA_I;
    if (REG_WR_EN_I && REG_ADDR_I == 8'h1e) io_next = REG_WR_DATA_I;
    if (REG_WR_EN_I && REG_ADDR_I == 8'h20) dc_next = REG_WR_DATA_I;
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      {sm_reg, so_reg, io_reg, dc_reg} <= {8'h64, 8'h80, 8'h0b, 8'h18};
    end else begin
      {sm_reg, so_reg, io_reg, dc_reg} <= {sm_next, so_next, io_next, dc_next};
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_pins_held;
    (!so_reg[0] && $stable(SPEED_PINS_I)) [*4];
  endsequence
  sequence s_rd_detect;
    REG_RD_EN_I && REG_ADDR_I == 8'h20;
  endsequence

  AST_SPEED_REG: assert property (!$past(SYS_RST_I) && $past(so_reg[0]) |->
    SPEED_MODE_O == $past(sm_reg[1:0])) else $error("speed mode not from register");
  AST_SPEED_PIN: assert property (s_pins_held |-> SPEED_MODE_O == SPEED_PINS_I)
    else $error("speed mode not from pins");
  AST_CHANNEL: assert property (!$past(SYS_RST_I) && $past(io_reg[7]) |->
    INPUT_CHANNEL_O == $past(dc_reg[2:1])) else $error("channel not from register");
  AST_FIRST: assert property (!$past(SYS_RST_I) |-> FIRST_OUT_SRC_O == first_src(
    $past(PIN_MODE_OVERRIDE_I) ? $past(io_reg[6:5]) : 2'h0, $past(LOCKED_I)))
    else $error("first output source wrong");
  AST_SECOND: assert property (!$past(SYS_RST_I) |-> SECOND_OUT_SRC_O == second_src(
    $past(PIN_MODE_OVERRIDE_I) ? $past(io_reg[4:3]) : 2'h1, $past(LOCKED_I)))
    else $error("second output source wrong");
  AST_LEVEL: assert property (!$past(SYS_RST_I) |->
    {DETECT_ASSERT_MV_O, DETECT_DEASSERT_MV_O} == thr($past(dc_reg[5:3])) &&
    DETECT_LEVEL_VALID_O == ($past(dc_reg[5:3]) >= 3'h3)) else $error("threshold wrong");
  AST_RESET: assert property ($fell(SYS_RST_I) |-> SECOND_OUT_SRC_O == RRC_SRC_BYPASS &&
    {DETECT_ASSERT_MV_O, DETECT_DEASSERT_MV_O} == {9'h070, 9'h04e})
    else $error("post-reset outputs wrong");
  AST_READ: assert property (s_rd_detect |=> REG_RD_DATA_O == $past(dc_reg))
    else $error("read data wrong");
endmodule : rrc_route_config_asserts

bind rrc_route_config rrc_route_config_asserts u_chk (.*);
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rrc_pkg::*;
  import rrc_vfy_pkg::*;
  logic       clk_sys, sys_rst, pin_mode, locked, wr_en, rd_en, reclock_in, lvl_ok;
  logic       force_on, force_off;
  logic [1:0] speed_pins, select_pins, in_ch;
  logic [3:0] sin = 4'h5;
  logic [7:0] reg_addr, wr_data, rd_data, seen;
  logic [8:0] det_a, det_d;
  rrc_speed_t speed_mode;
  rrc_src_t   first_out, second_out;
  int         n_mismatch, compares;
  logic [7:0] rd_exp [8] = '{8'h00, 8'h64, 8'h80, 8'h0b, 8'h55, 8'h18, 8'h05, 8'h00};

  always #10 clk_sys = ~clk_sys;

  rrc_route_config DUT (.CLK_SYS_I(clk_sys), .SYS_RST_I(sys_rst), .REG_ADDR_I(reg_addr),
    .REG_WR_EN_I(wr_en), .REG_WR_DATA_I(wr_data), .REG_RD_EN_I(rd_en), .REG_RD_DATA_O(rd_data),
    .PIN_MODE_OVERRIDE_I(pin_mode), .SPEED_PINS_I(speed_pins), .SELECT_PINS_I(select_pins),
    .SERIAL_IN_I(sin), .LOCKED_I(locked), .SPEED_MODE_O(speed_mode), .INPUT_CHANNEL_O(in_ch),
    .RECLOCK_IN_O(reclock_in), .FIRST_OUT_SRC_O(first_out), .SECOND_OUT_SRC_O(second_out),
    .DETECT_ASSERT_MV_O(det_a), .DETECT_DEASSERT_MV_O(det_d), .DETECT_LEVEL_VALID_O(lvl_ok),
    .DETECT_FORCE_ON_O(force_on), .DETECT_FORCE_OFF_O(force_off));
  rrc_host u_host (.clk_i(clk_sys), .addr_o(reg_addr), .wr_en_o(wr_en), .wr_data_o(wr_data),
    .rd_en_o(rd_en), .rd_data_i(rd_data));

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  initial begin
    {clk_sys, sys_rst, pin_mode, locked, speed_pins, select_pins} = 8'h7b;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      u_host.rd(8'h1b + i[7:0], seen);
      chk(seen, rd_exp[i]);
    end
    chk(speed_mode, 2'h2);
    chk(in_ch, 2'h3);
    chk({force_on, force_off}, 2'h0);
    $display("reset test done");
    u_host.wr(8'h1d, 8'h81);
    for (int c = 0; c < 4; c++) begin
      u_host.wr(8'h1c, {6'h19, c[1:0]});
      settle(1);
      chk(speed_mode, c[1:0]);
    end
    u_host.wr(8'h1d, 8'h80);
    @(posedge clk_sys);
    speed_pins <= 2'h1;
    settle(4);
    chk(speed_mode, 2'h1);
    $display("speed test done");
    u_host.wr(8'h1e, 8'h8b);
    for (int i = 0; i < 8; i++) begin
      u_host.wr(8'h20, {2'h0, i[2:0], i[1:0], 1'b0});
      settle(2);
      chk(in_ch, i[1:0]);
      chk(reclock_in, sin[i[1:0]]);
      chk({det_a, det_d}, thr(i[2:0]));
      chk(lvl_ok, i >= 3);
    end
    u_host.wr(8'h20, 8'h98);
    settle(1);
    chk({force_on, force_off}, 2'h2);
    u_host.wr(8'h20, 8'h58);
    settle(1);
    chk({force_on, force_off}, 2'h1);
    u_host.wr(8'h20, 8'h18);
    $display("channel and level test done");
    for (int m = 0; m < 64; m++) begin
      @(posedge clk_sys);
      pin_mode <= m[5];
      locked <= m[4];
      u_host.wr(8'h1e, {1'b1, m[3:2], m[1:0], 3'h3});
      settle(1);
      chk(first_out, first_src(m[5] ? m[3:2] : 2'h0, m[4]));
      chk(second_out, second_src(m[5] ? m[1:0] : 2'h1, m[4]));
    end
    $display("routing test done");
    wrap_up();
  end

  // The whole run needs well under a thousand cycles; this limit leaves a wide margin.
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
